// ---- pkg/dctp_pkg.sv ----
/*
 package of the dual channel timer pwm pulse block: codes, counts, carriers.
 assumes one clock domain and a timer tick enable from the same domain.
*/
package dctp_pkg;
   // ***************************
   // constants
   // ***************************
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] TMODE_TC = 2'h3;
   localparam logic [1:0] PF_INACT = 2'h0;
   localparam logic [1:0] PF_ACT = 2'h1;
   localparam logic [1:0] PF_PWM = 2'h2;
   localparam logic [1:0] PF_SPM = 2'h3;
   localparam logic [1:0] CA_LOW = 2'h1;
   localparam logic [1:0] CA_HIGH = 2'h2;
   localparam logic [1:0] CA_TOG = 2'h3;
   localparam logic [1:0] ALIGN_EDGE = 2'h0;
   localparam logic [1:0] ALIGN_UP = 2'h1;
   localparam logic [1:0] ALIGN_DN = 2'h2;
   localparam logic [1:0] ALIGN_BOTH = 2'h3;
   localparam logic [2:0] CODE_FULL = 3'h0;
   localparam logic [10:0] EDGE_FULL = 11'h400;
   localparam logic [10:0] CTR_FULL_HALF = 11'h3ff;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [9:0] CNT_ONE = 10'h001;

   // ***************************
   // types
   // ***************************
   typedef enum logic [4:0] {
      MD_IDLE = 5'h01,
      MD_CMP = 5'h02,
      MD_TC = 5'h04,
      MD_PWM = 5'h08,
      MD_SPM = 5'h10
   } dctp_mode_type;

   typedef struct packed {
      logic [1:0] timer_mode_bits;
      logic [1:0] channel_a_mode_bits;
      logic [1:0] channel_b_mode_bits;
      logic [1:0] channel_a_pin_function;
      logic [1:0] channel_b_pin_function;
      logic channel_a_output_level;
      logic channel_b_output_level;
      logic channel_a_polarity_invert;
      logic channel_b_polarity_invert;
      logic [1:0] alignment_select;
      logic clear_source_select;
   } dctp_cfg_type;

   typedef struct packed {
      logic [9:0] cnt;
      logic dir_down;
      logic run;
      logic trig_s1;
      logic trig_s2;
      logic trig_prev;
      logic sp_b_on;
      logic pin_a;
      logic pin_b;
      logic pin_bb;
      logic oe_a;
      logic oe_b;
      logic flag_a;
      logic flag_b;
      logic flag_p;
   } dctp_state_type;

   localparam dctp_state_type STATE_RST = '0;
endpackage

// ---- hw/dctp_timer.sv ----
/*
 dual channel 10-bit timer: compare match, timer/counter, edge and centre
 pwm, single pulse. assumes timer_tick_in is a one-cycle enable on clk_in
 and that software pulses never need more than one cycle to act.
*/
`timescale 1ns/10ps
// Contract
// - compare mode, clear high: A match clears counter, no period flag.
// - compare mode pins change only on their own channel match or at run rise.
// - run rise returns compare pins to their initial levels.
// - timer/counter mode counts like compare mode, pins left free.
// - pwm mode: both mode pairs 10 and pin functions 10.
// - pwm, clear source high: A sets period, B sets duty, pin A unused.
// - edge pwm, clear source low: period code times 128, zero means 1024.
// - duty at or above period gives 100% duty.
// - edge pwm leading edges start together at counter zero.
// - edge pwm, clear high: period equals compare A, B duty equals B.
// - centre pwm, code period 256 per step, zero gives 2046, duty 2c-1.
// - centre pwm, clear source high: period twice compare A, duty 2B-1.
// - centre alignment places both pulse centres together at counter zero.
// - centre pwm raises period flag when counting down to zero.
// - pwm raises separate A, B and period match flags; edge pwm, clear high: A flag at wrap, no period flag.
// - pin function 00 or 01 forces the pin while pwm keeps running.
// - output level selects active sense, polarity bit inverts output.
// - single pulse mode: mode pairs 10, pin functions 11.
// - trigger pin edge sets run; run rise starts counter and pulse A.
// - pulse B starts at channel B match, width A minus B.
// - A match or software clear ends pulses; A and B raise flags.
// - single pulse counter reset only at run rise; code, clear ignored.
// - alignment 00 edge, 01 up, 10 down, 11 both directions.
// - pin function 00 inactive, 01 active, 10 pwm, 11 single pulse.
// - counter and compare values are 10 bits, counter read as two bytes.
module dctp_timer (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic timer_tick_in,
   input wire dctp_pkg::dctp_cfg_type cfg_in,
   input wire logic [9:0] compare_value_a_in,
   input wire logic [9:0] compare_value_b_in,
   input wire logic [2:0] period_code_in,
   input wire logic run_set_in,
   input wire logic run_clear_in,
   input wire logic external_trigger_pin_in,
   input wire logic [2:0] flag_clear_in,
   output logic run_control_out,
   output logic output_pin_a_out,
   output logic output_pin_a_oe_out,
   output logic output_pin_b_out,
   output logic output_pin_b_complement_out,
   output logic output_pin_b_oe_out,
   output logic match_a_flag_out,
   output logic match_b_flag_out,
   output logic period_match_flag_out,
   output logic [7:0] counter_low_out,
   output logic [1:0] counter_high_out
);
   // ***************************
   // state and decode
   // ***************************
   dctp_pkg::dctp_state_type s_q;
   dctp_pkg::dctp_state_type s_d;
   dctp_pkg::dctp_mode_type mode;
   logic clr;
   logic centre;
   logic [10:0] per_code;
   logic [10:0] edge_top;
   logic [10:0] half;
   logic match_a;
   logic match_b;
   logic trig_edge;
   logic run_n;
   logic rise;
   logic act_a;
   logic act_b;
   logic set_a;
   logic set_b;
   logic set_p;

   assign clr = cfg_in.clear_source_select;
   assign centre = cfg_in.alignment_select != dctp_pkg::ALIGN_EDGE;
   assign match_a = s_q.cnt == compare_value_a_in;
   assign match_b = s_q.cnt == compare_value_b_in;
   assign trig_edge = s_q.trig_s2 & ~s_q.trig_prev;

   // code zero stands for the full range in both alignments
   always_comb begin
      if (period_code_in == dctp_pkg::CODE_FULL) begin
         per_code = dctp_pkg::EDGE_FULL;
      end else begin
         per_code = {1'b0, period_code_in, 7'h00};
      end
      edge_top = clr ? ({1'b0, compare_value_a_in} - 11'h001)
                     : (per_code - 11'h001);
      if (clr) begin
         half = {1'b0, compare_value_a_in};
      end else if (period_code_in == dctp_pkg::CODE_FULL) begin
         half = dctp_pkg::CTR_FULL_HALF;
      end else begin
         half = per_code;
      end
   end

   always_comb begin
      if (cfg_in.timer_mode_bits == dctp_pkg::TMODE_TC) begin
         mode = dctp_pkg::MD_TC;
      end else if (cfg_in.channel_a_mode_bits == dctp_pkg::MODE_PWM &&
                   cfg_in.channel_b_mode_bits == dctp_pkg::MODE_PWM) begin
         if (cfg_in.channel_a_pin_function == dctp_pkg::PF_SPM &&
             cfg_in.channel_b_pin_function == dctp_pkg::PF_SPM) begin
            mode = dctp_pkg::MD_SPM;
         end else begin
            mode = dctp_pkg::MD_PWM;
         end
      end else if (cfg_in.channel_a_mode_bits == dctp_pkg::MODE_CMP &&
                   cfg_in.channel_b_mode_bits == dctp_pkg::MODE_CMP) begin
         mode = dctp_pkg::MD_CMP;
      end else begin
         mode = dctp_pkg::MD_IDLE;
      end
   end

   // same compare serves edge and centre: cnt below duty means active
   assign act_a = s_q.cnt < compare_value_a_in;
   assign act_b = s_q.cnt < compare_value_b_in;

   function automatic logic drive(input logic act, input logic lvl,
                                  input logic inv, input logic [1:0] pf);
      logic a;
      a = act;
      if (pf == dctp_pkg::PF_INACT) begin
         a = 1'b0;
      end else if (pf == dctp_pkg::PF_ACT) begin
         a = 1'b1;
      end
      drive = (a ? lvl : ~lvl) ^ inv;
   endfunction

   function automatic logic cmp_act(input logic cur, input logic [1:0] pf);
      cmp_act = cur;
      if (pf == dctp_pkg::CA_LOW) begin
         cmp_act = 1'b0;
      end else if (pf == dctp_pkg::CA_HIGH) begin
         cmp_act = 1'b1;
      end else if (pf == dctp_pkg::CA_TOG) begin
         cmp_act = ~cur;
      end
   endfunction

   // ***************************
   // next state
   // ***************************
   always_comb begin
      s_d = s_q;
      set_a = 1'b0;
      set_b = 1'b0;
      set_p = 1'b0;
      s_d.trig_s1 = external_trigger_pin_in;
      s_d.trig_s2 = s_q.trig_s1;
      s_d.trig_prev = s_q.trig_s2;
      run_n = s_q.run;
      if (run_clear_in) begin
         run_n = 1'b0;
      end
      if (mode == dctp_pkg::MD_SPM && timer_tick_in && s_q.run &&
          match_a) begin
         run_n = 1'b0;
      end
      if (run_set_in) begin
         run_n = 1'b1;
      end
      if (mode == dctp_pkg::MD_SPM && trig_edge) begin
         run_n = 1'b1;
      end
      rise = run_n & ~s_q.run;
      s_d.run = run_n;
      if (rise) begin
         s_d.cnt = dctp_pkg::CNT_RST;
         s_d.dir_down = 1'b0;
         s_d.sp_b_on = 1'b0;
      end else if (s_q.run && timer_tick_in) begin
         unique case (mode)
            dctp_pkg::MD_CMP, dctp_pkg::MD_TC: begin
               set_a = match_a;
               set_b = match_b;
               set_p = ~clr && {1'b0, s_q.cnt} == edge_top;
               if (clr ? match_a : set_p) begin
                  s_d.cnt = dctp_pkg::CNT_RST;
               end else begin
                  s_d.cnt = s_q.cnt + dctp_pkg::CNT_ONE;
               end
            end
            dctp_pkg::MD_PWM: begin
               set_b = match_b;
               if (!centre) begin
                  set_a = match_a;
                  if ({1'b0, s_q.cnt} == edge_top) begin
                     s_d.cnt = dctp_pkg::CNT_RST;
                     set_p = ~clr;
                     // clear high: the wrap is the channel A match
                     set_a = match_a | clr;
                  end else begin
                     s_d.cnt = s_q.cnt + dctp_pkg::CNT_ONE;
                  end
               end else if (!s_q.dir_down) begin
                  set_a = match_a && cfg_in.alignment_select !=
                          dctp_pkg::ALIGN_DN;
                  s_d.cnt = s_q.cnt + dctp_pkg::CNT_ONE;
                  s_d.dir_down = {1'b0, s_d.cnt} >= half;
               end else begin
                  set_a = match_a && cfg_in.alignment_select !=
                          dctp_pkg::ALIGN_UP;
                  s_d.cnt = s_q.cnt - dctp_pkg::CNT_ONE;
                  if (s_q.cnt == dctp_pkg::CNT_ONE) begin
                     s_d.dir_down = 1'b0;
                     set_p = 1'b1;
                  end
               end
            end
            dctp_pkg::MD_SPM: begin
               set_a = match_a;
               set_b = match_b;
               s_d.cnt = s_q.cnt + dctp_pkg::CNT_ONE;
               if (match_b) begin
                  s_d.sp_b_on = 1'b1;
               end
            end
            dctp_pkg::MD_IDLE: begin
            end
         endcase
      end
      // set wins over a clear landing in the same cycle
      s_d.flag_a = (s_q.flag_a & ~flag_clear_in[0]) | set_a;
      s_d.flag_b = (s_q.flag_b & ~flag_clear_in[1]) | set_b;
      s_d.flag_p = (s_q.flag_p & ~flag_clear_in[2]) | set_p;
      s_d.oe_a = 1'b0;
      s_d.oe_b = 1'b0;
      unique case (mode)
         dctp_pkg::MD_CMP: begin
            s_d.oe_a = 1'b1;
            s_d.oe_b = 1'b1;
            if (rise) begin
               s_d.pin_a = cfg_in.channel_a_output_level;
               s_d.pin_b = cfg_in.channel_b_output_level;
            end else begin
               if (set_a) begin
                  s_d.pin_a = cmp_act(s_q.pin_a,
                                      cfg_in.channel_a_pin_function);
               end
               if (set_b) begin
                  s_d.pin_b = cmp_act(s_q.pin_b,
                                      cfg_in.channel_b_pin_function);
               end
            end
         end
         dctp_pkg::MD_PWM: begin
            s_d.oe_a = ~clr;
            s_d.oe_b = 1'b1;
            s_d.pin_a = drive(act_a & ~clr, cfg_in.channel_a_output_level,
                              cfg_in.channel_a_polarity_invert,
                              clr ? dctp_pkg::PF_INACT
                                  : cfg_in.channel_a_pin_function);
            s_d.pin_b = drive(act_b, cfg_in.channel_b_output_level,
                              cfg_in.channel_b_polarity_invert,
                              cfg_in.channel_b_pin_function);
         end
         dctp_pkg::MD_SPM: begin
            s_d.oe_a = 1'b1;
            s_d.oe_b = 1'b1;
            s_d.pin_a = drive(s_d.run, cfg_in.channel_a_output_level,
                              cfg_in.channel_a_polarity_invert,
                              dctp_pkg::PF_SPM);
            s_d.pin_b = drive(s_d.run & s_d.sp_b_on,
                              cfg_in.channel_b_output_level,
                              cfg_in.channel_b_polarity_invert,
                              dctp_pkg::PF_SPM);
         end
         dctp_pkg::MD_TC, dctp_pkg::MD_IDLE: begin
            // pins released for general use
         end
      endcase
      s_d.pin_bb = ~s_d.pin_b;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q <= dctp_pkg::STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************
   // outputs
   // ***************************
   assign run_control_out = s_q.run;
   assign output_pin_a_out = s_q.pin_a;
   assign output_pin_a_oe_out = s_q.oe_a;
   assign output_pin_b_out = s_q.pin_b;
   assign output_pin_b_complement_out = s_q.pin_bb;
   assign output_pin_b_oe_out = s_q.oe_b;
   assign match_a_flag_out = s_q.flag_a;
   assign match_b_flag_out = s_q.flag_b;
   assign period_match_flag_out = s_q.flag_p;
   assign counter_low_out = s_q.cnt[7:0];
   assign counter_high_out = s_q.cnt[9:8];

   // ***************************
   // assertions
   // ***************************
   property p_no_pflag;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_CMP && clr && !s_q.flag_p) |=> !s_q.flag_p;
   endproperty
   a_no_pflag: assert property (p_no_pflag)
      else $error("period flag raised with clear source high");

   property p_init_level;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_CMP && rise) |=>
         s_q.pin_a == $past(cfg_in.channel_a_output_level);
   endproperty
   a_init_level: assert property (p_init_level)
      else $error("pin a not at initial level after run rise");

   property p_run_rise_zero;
      @(posedge clk_in) disable iff (reset_in)
      $rose(s_q.run) |-> s_q.cnt == dctp_pkg::CNT_RST;
   endproperty
   a_run_rise_zero: assert property (p_run_rise_zero)
      else $error("counter not zero after run rise");

   property p_sp_end;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_SPM && timer_tick_in && s_q.run && match_a &&
       !run_set_in && !trig_edge) |=> !s_q.run &&
         s_q.pin_a == (~cfg_in.channel_a_output_level ^
                       cfg_in.channel_a_polarity_invert) &&
         s_q.pin_b == (~cfg_in.channel_b_output_level ^
                       cfg_in.channel_b_polarity_invert);
   endproperty
   a_sp_end: assert property (p_sp_end)
      else $error("single pulse not ended by channel a match");

   property p_full_duty;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_PWM && !centre && !clr && s_q.run && !rise &&
       cfg_in.channel_b_pin_function == dctp_pkg::PF_PWM &&
       {1'b0, compare_value_b_in} >= per_code) |=>
         s_q.pin_b == (cfg_in.channel_b_output_level ^
                       cfg_in.channel_b_polarity_invert);
   endproperty
   a_full_duty: assert property (p_full_duty)
      else $error("duty above period not held active");

   property p_forced;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_PWM && !clr &&
       cfg_in.channel_a_pin_function == dctp_pkg::PF_INACT) |=>
         s_q.pin_a == (~cfg_in.channel_a_output_level ^
                       cfg_in.channel_a_polarity_invert);
   endproperty
   a_forced: assert property (p_forced)
      else $error("forced inactive pin a wrong");

   property p_lead_edge;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_PWM && !centre && !clr &&
       s_q.cnt == dctp_pkg::CNT_RST && compare_value_a_in != 10'h000 &&
       compare_value_b_in != 10'h000 &&
       cfg_in.channel_a_pin_function == dctp_pkg::PF_PWM &&
       cfg_in.channel_b_pin_function == dctp_pkg::PF_PWM) |=>
         s_q.pin_a == (cfg_in.channel_a_output_level ^
                       cfg_in.channel_a_polarity_invert) &&
         s_q.pin_b == (cfg_in.channel_b_output_level ^
                       cfg_in.channel_b_polarity_invert);
   endproperty
   a_lead_edge: assert property (p_lead_edge)
      else $error("leading edges not together at zero");

   property p_centre_pflag;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_PWM && centre && timer_tick_in && s_q.run &&
       !rise && s_q.dir_down && s_q.cnt == dctp_pkg::CNT_ONE) |=>
         s_q.flag_p && s_q.cnt == dctp_pkg::CNT_RST;
   endproperty
   a_centre_pflag: assert property (p_centre_pflag)
      else $error("no period flag at centre bottom");

   property p_trigger;
      @(posedge clk_in) disable iff (reset_in)
      (mode == dctp_pkg::MD_SPM && $rose(external_trigger_pin_in) &&
       !run_clear_in) ##1 (mode == dctp_pkg::MD_SPM && !run_clear_in)[*3]
         |-> ##[0:1] s_q.run;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("trigger edge did not set run");

   c_cmp_toggle: cover property (@(posedge clk_in) disable iff (reset_in)
      mode == dctp_pkg::MD_CMP && set_a ##1 $changed(s_q.pin_a));
   c_pwm_wrap: cover property (@(posedge clk_in) disable iff (reset_in)
      mode == dctp_pkg::MD_PWM && set_p);
   c_sp_done: cover property (@(posedge clk_in) disable iff (reset_in)
      mode == dctp_pkg::MD_SPM && s_q.sp_b_on ##1 $fell(s_q.run));
endmodule

// ---- verification/dctp_load.sv ----
/*
 external load on one timer output pin: counts clock cycles with the pin on.
 assumes a pull-down on the wire, so a released pin reads low.
*/
`timescale 1ns/10ps
module dctp_load (
   input wire logic clk_in,
   input wire logic pin_in,
   input wire logic oe_in,
   input wire logic clear_in,
   output logic level_out,
   output logic [11:0] on_cycles_out
);
   // released pin falls to the pull-down, never keeps its last value
   assign level_out = oe_in ? pin_in : 1'b0;
   always_ff @(posedge clk_in) begin
      if (clear_in) begin
         on_cycles_out <= 12'h000;
      end else if (level_out) begin
         on_cycles_out <= on_cycles_out + 12'h001;
      end
   end
endmodule

// ---- verification/dual_channel_timer_pwm_pulse_tb.sv ----
/*
 self-checking bench of the dual channel timer: compare, timer/counter,
 edge and centre pwm, single pulse. assumes the timer and two pin loads.
*/
`timescale 1ns/10ps
module dual_channel_timer_pwm_pulse_tb;
   typedef struct {int sel; logic [11:0] exp;} dctp_note_type;
   logic clk_in, reset_in, tick, run_set, run_clr, trig, ld_clr;
   dctp_pkg::dctp_cfg_type cfg;
   logic [9:0] cva, cvb;
   logic [2:0] pcode, fclr;
   logic run, pa, pa_oe, pb, pbb, pb_oe, fa, fb, fp;
   logic [7:0] cnt_lo, lfsr;
   logic [1:0] cnt_hi;
   logic [11:0] on_a, on_b;
   int errors, checks_done;
   dctp_note_type notes[$];
   event seen_ev;
   string nm [0:11] = '{"run", "pin_a", "pin_b", "flag_a", "flag_b",
      "flag_p", "counter", "load_a", "load_b", "oe_a", "pin_bb", "oe_b"};

   dctp_timer i_dctp_timer (.clk_in(clk_in), .reset_in(reset_in),
      .timer_tick_in(tick), .cfg_in(cfg), .compare_value_a_in(cva),
      .compare_value_b_in(cvb), .period_code_in(pcode),
      .run_set_in(run_set), .run_clear_in(run_clr),
      .external_trigger_pin_in(trig), .flag_clear_in(fclr),
      .run_control_out(run), .output_pin_a_out(pa),
      .output_pin_a_oe_out(pa_oe), .output_pin_b_out(pb),
      .output_pin_b_complement_out(pbb), .output_pin_b_oe_out(pb_oe),
      .match_a_flag_out(fa), .match_b_flag_out(fb),
      .period_match_flag_out(fp), .counter_low_out(cnt_lo),
      .counter_high_out(cnt_hi));
   dctp_load i_dctp_load_a (.clk_in(clk_in), .pin_in(pa), .oe_in(pa_oe),
      .clear_in(ld_clr), .level_out(), .on_cycles_out(on_a));
   dctp_load i_dctp_load_b (.clk_in(clk_in), .pin_in(pb), .oe_in(pb_oe),
      .clear_in(ld_clr), .level_out(), .on_cycles_out(on_b));

   // ***************************
   // helpers
   // ***************************
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic dctp_pkg::dctp_cfg_type mk(input logic [1:0] tm, m,
         pa_f, pb_f, al, input logic lv, po, cl);
      return '{tm, m, m, pa_f, pb_f, lv, lv, po, po, al, cl};
   endfunction
   function automatic logic [11:0] obs(input int s);
      case (s)
         0: return {11'h000, run};
         1: return {11'h000, pa};
         2: return {11'h000, pb};
         3: return {11'h000, fa};
         4: return {11'h000, fb};
         5: return {11'h000, fp};
         6: return {2'h0, cnt_hi, cnt_lo};
         7: return on_a;
         8: return on_b;
         9: return {11'h000, pa_oe};
         10: return {11'h000, pbb};
         default: return {11'h000, pb_oe};
      endcase
   endfunction
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input int s, input logic [11:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm[s], exp, seen);
      end
   endtask
   task automatic note(input int s, input logic [11:0] e);
      notes.push_back('{s, e});
      -> seen_ev;
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic ticks(input int n);
      tick = 1'b1;
      step(n);
      tick = 1'b0;
   endtask
   task automatic measure(input int p);
      ld_clr = 1'b1;
      step(1);
      ld_clr = 1'b0;
      step(p);
   endtask
   // config only changes with run low, then a fresh run rise
   task automatic start(input dctp_pkg::dctp_cfg_type c);
      tick = 1'b0;
      run_clr = 1'b1;
      fclr = 3'h7;
      step(1);
      run_clr = 1'b0;
      fclr = 3'h0;
      cfg = c;
      run_set = 1'b1;
      step(1);
      run_set = 1'b0;
      step(1);
   endtask
   task automatic wait_run(input logic v);
      int k;
      k = 0;
      while (run !== v && k < 40) begin
         step(1);
         k++;
      end
      if (k == 40) begin
         errors++;
         report_and_stop();
      end
   endtask

   // ***************************
   // clock, monitor, watchdog
   // ***************************
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      dctp_note_type n;
      forever begin
         @(seen_ev);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            check(n.sel, obs(n.sel), n.exp);
         end
      end
   end
   initial begin
      repeat (60000) @(posedge clk_in);
      errors++;
      report_and_stop();
   end

   // ***************************
   // scenarios
   // ***************************
   initial begin
      {tick, run_set, run_clr, trig, ld_clr} = 5'h00;
      cfg = '0;
      {cva, cvb, pcode, fclr} = 26'h0000000;
      lfsr = 8'h4e;
      reset_in = 1'b1;
      step(12);
      reset_in = 1'b0;
      for (int s = 0; s < 7; s++) begin
         note(s, 12'h000);
      end
      // edge pwm, random duties; second pass flips both level and polarity bits (same pin sense) and forces pin a
      pcode = 3'h1;
      for (int i = 0; i < 2; i++) begin
         lfsr = nxt(lfsr);
         cva = {2'h0, lfsr};
         lfsr = nxt(lfsr);
         cvb = {2'h0, lfsr};
         start(mk(2'h0, dctp_pkg::MODE_PWM,
            i ? dctp_pkg::PF_INACT : dctp_pkg::PF_PWM, dctp_pkg::PF_PWM,
            dctp_pkg::ALIGN_EDGE, i ? 1'b0 : 1'b1, i ? 1'b1 : 1'b0, 1'b0));
         tick = 1'b1;
         step(130);
         measure(128);
         note(7, i ? 12'h000 : cva >= 10'h080 ? 12'h080 : {2'h0, cva});
         note(8, cvb >= 10'h080 ? 12'h080 : {2'h0, cvb});
         note(4, {11'h000, cvb < 10'h080});
         note(3, {11'h000, cva < 10'h080});
         note(5, 12'h001);
         note(9, 12'h001);
         note(11, 12'h001);
      end
      // centre pwm, period from compare a = 4, duty b = 2
      cva = 10'h004;
      cvb = 10'h002;
      for (int al = 1; al < 4; al++) begin
         start(mk(2'h0, dctp_pkg::MODE_PWM, dctp_pkg::PF_PWM,
            dctp_pkg::PF_PWM, 2'(al), 1'b1, 1'b0, 1'b1));
         ticks(7);
         step(2);
         note(6, 12'h001);
         note(5, 12'h000);
         ticks(1);
         step(2);
         note(5, 12'h001);
         tick = 1'b1;
         measure(8);
         note(8, 12'h003);
         note(4, 12'h001);
         note(9, 12'h000);
      end
      // edge pwm, period from compare a = 6, duty b = 2
      cva = 10'h006;
      cvb = 10'h002;
      start(mk(2'h0, dctp_pkg::MODE_PWM, dctp_pkg::PF_PWM,
         dctp_pkg::PF_PWM, dctp_pkg::ALIGN_EDGE, 1'b1, 1'b0, 1'b1));
      tick = 1'b1;
      measure(6);
      note(8, 12'h002);
      note(3, 12'h001);
      note(5, 12'h000);
      // compare mode, clear on a match, toggling pin a, pin b driven low
      cva = 10'h00a;
      cvb = 10'h005;
      start(mk(2'h0, dctp_pkg::MODE_CMP, dctp_pkg::CA_TOG, dctp_pkg::CA_LOW,
         dctp_pkg::ALIGN_EDGE, 1'b1, 1'b0, 1'b1));
      note(1, 12'h001);
      ticks(11);
      step(2);
      note(1, 12'h000);
      note(3, 12'h001);
      note(6, 12'h000);
      ticks(200);
      step(2);
      note(5, 12'h000);
      note(2, 12'h000);
      note(10, 12'h001);
      start(cfg);
      note(1, 12'h001);
      note(2, 12'h001);
      // timer/counter mode, pins left to other uses
      start(mk(dctp_pkg::TMODE_TC, dctp_pkg::MODE_CMP, dctp_pkg::CA_TOG,
         dctp_pkg::CA_TOG, dctp_pkg::ALIGN_EDGE, 1'b1, 1'b0, 1'b0));
      ticks(5);
      step(2);
      note(6, 12'h005);
      note(9, 12'h000);
      note(11, 12'h000);
      ticks(200);
      step(2);
      note(5, 12'h001);
      note(3, 12'h001);
      // single pulse from the trigger pin
      cva = 10'h014;
      cvb = 10'h008;
      run_clr = 1'b1;
      fclr = 3'h7;
      step(1);
      run_clr = 1'b0;
      fclr = 3'h0;
      cfg = mk(2'h0, dctp_pkg::MODE_PWM, dctp_pkg::PF_SPM,
         dctp_pkg::PF_SPM, dctp_pkg::ALIGN_EDGE, 1'b1, 1'b0, 1'b0);
      ld_clr = 1'b1;
      trig = 1'b1;
      step(1);
      ld_clr = 1'b0;
      wait_run(1'b1);
      note(0, 12'h001);
      // run left high until the a match ends the pulse
      tick = 1'b1;
      wait_run(1'b0);
      tick = 1'b0;
      trig = 1'b0;
      step(3);
      note(8, 12'h00c);
      note(3, 12'h001);
      note(4, 12'h001);
      start(cfg);
      note(6, 12'h000);
      note(1, 12'h001);
      step(2);
      report_and_stop();
   end
endmodule
